// ---- core/hphe_engine.sv ----
`timescale 1ns/10ps
`default_nettype none
module hphe_engine #(
  parameter int unsigned GAP_CYCLES = hphe_pkg::GAP_CYCLES,
  parameter int unsigned REPLY_CYCLES = hphe_pkg::REPLY_CYCLES,
  parameter int unsigned MAX_DATA = hphe_pkg::MAX_DATA
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [hphe_pkg::ADDR_W-1:0] MY_ADDR,
  input wire logic RX_VALID,
  input wire logic [hphe_pkg::BYTE_W-1:0] RX_DATA,
  output logic RX_READY,
  output logic TX_VALID,
  output logic [hphe_pkg::BYTE_W-1:0] TX_DATA,
  input wire logic TX_READY,
  output logic CMD_VALID,
  output logic [hphe_pkg::BYTE_W-1:0] CMD_NUM,
  output logic [hphe_pkg::BYTE_W-1:0] CMD_LEN,
  output logic CMD_BCAST,
  input wire logic [hphe_pkg::BYTE_W-1:0] CMD_IDX,
  output logic [hphe_pkg::BYTE_W-1:0] CMD_RDATA,
  input wire logic RSP_VALID,
  output logic RSP_READY,
  input wire logic RSP_IS_DATA,
  input wire logic [hphe_pkg::BYTE_W-1:0] RSP_STATUS,
  input wire logic [hphe_pkg::BYTE_W-1:0] RSP_LEN,
  output logic [hphe_pkg::BYTE_W-1:0] RSP_IDX,
  input wire logic [hphe_pkg::BYTE_W-1:0] RSP_RDATA,
  output logic RSP_DONE
);
  import hphe_pkg::*;

  hphe_state_t state_ff;
  hphe_state_t nxt_state;
  hphe_field_t rx_field_ff;
  hphe_field_t nxt_rx_field;
  hphe_field_t tx_field_ff;
  hphe_field_t nxt_tx_field;

  logic [ADDR_W-1:0] rx_addr_ff;
  logic [7:0] rx_cmd_ff;
  logic [7:0] rx_len_ff;
  logic [7:0] rx_idx_ff;
  logic [7:0] rx_xor_ff;
  logic [7:0] rx_mem_ff [MAX_DATA];
  logic [7:0] cmd_rdata_ff;
  logic cmd_valid_ff;
  logic cmd_bcast_ff;
  logic ack_ok_ff;

  logic rsp_is_data_ff;
  logic [7:0] rsp_status_ff;
  logic [7:0] rsp_len_ff;
  logic [7:0] tx_idx_ff;
  logic [7:0] tx_xor_ff;
  logic [7:0] tx_byte;
  logic rsp_done_ff;

  logic rx_fire;
  logic reply_fire;
  logic reply_known;
  logic pkt_end;
  logic sum_ok;
  logic addr_me;
  logic addr_bcast;
  logic gap_run;
  logic gap_expired;
  logic reply_run;
  logic reply_expired;
  logic buf_in_valid;
  logic buf_in_ready;
  logic [7:0] buf_in_data;
  logic tx_push;
  logic enter_send;

  // ---------------------------------------------------------------
  // receive handshake
  // ---------------------------------------------------------------
  // fixed reply codes
  assign reply_known = (RX_DATA == ACK_BYTE) || (RX_DATA == NAK_BYTE);
  // an unknown byte during the reply wait is left in place so that the
  // receiver picks it up next cycle as the start of a new packet
  assign RX_READY = (state_ff == ST_RECV) ||
                    ((state_ff == ST_REPLY) && reply_known);
  assign rx_fire = RX_VALID && (state_ff == ST_RECV);
  assign reply_fire = RX_VALID && (state_ff == ST_REPLY) && reply_known;

  // ---------------------------------------------------------------
  // packet parsing
  // ---------------------------------------------------------------
  always_comb begin
    nxt_rx_field = F_HDR;
    unique case (rx_field_ff)
      F_HDR: nxt_rx_field = next_field(F_HDR, 8'h00, 8'h00);
      // long count selects a length byte
      F_CMD: nxt_rx_field = next_field(F_CMD, rx_len_ff, 8'h00);
      F_LEN: nxt_rx_field = next_field(F_LEN, RX_DATA, 8'h00);
      F_DATA: nxt_rx_field = next_field(F_DATA, rx_len_ff, rx_idx_ff);
      F_SUM: nxt_rx_field = F_HDR;
      default: nxt_rx_field = F_HDR;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rx_field_ff <= F_HDR;
    end else if (gap_expired || (state_ff != ST_RECV)) begin
      rx_field_ff <= F_HDR;
    end else if (rx_fire) begin
      rx_field_ff <= nxt_rx_field;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rx_addr_ff <= BCAST_ADDR;
      rx_cmd_ff <= RST_BYTE;
      rx_len_ff <= RST_BYTE;
      rx_idx_ff <= RST_BYTE;
    end else if (rx_fire) begin
      unique case (rx_field_ff)
        F_HDR: begin
          rx_addr_ff <= RX_DATA[7:HDR_ADDR_LSB];
          rx_len_ff <= {5'h00, RX_DATA[CNT_W-1:0]};
          rx_idx_ff <= RST_BYTE;
        end
        F_CMD: rx_cmd_ff <= RX_DATA;
        F_LEN: rx_len_ff <= RX_DATA;
        F_DATA: rx_idx_ff <= rx_idx_ff + 8'h01;
        F_SUM: rx_idx_ff <= rx_idx_ff;
        default: rx_idx_ff <= rx_idx_ff;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rx_xor_ff <= RST_BYTE;
    end else if (rx_fire) begin
      rx_xor_ff <= (rx_field_ff == F_HDR) ? RX_DATA : (rx_xor_ff ^ RX_DATA);
    end
  end

  // data beyond the store is checked but not kept
  always_ff @(posedge CLK) begin
    if (rx_fire && (rx_field_ff == F_DATA) && (rx_idx_ff < 8'(MAX_DATA))) begin
      rx_mem_ff[rx_idx_ff] <= RX_DATA;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cmd_rdata_ff <= RST_BYTE;
    end else begin
      cmd_rdata_ff <= (CMD_IDX < 8'(MAX_DATA)) ? rx_mem_ff[CMD_IDX] : RST_BYTE;
    end
  end

  // ---------------------------------------------------------------
  // verify phase
  // ---------------------------------------------------------------
  // address and checksum test
  assign pkt_end = rx_fire && (rx_field_ff == F_SUM);
  assign sum_ok = ((rx_xor_ff ^ RX_DATA) == 8'h00);
  assign addr_bcast = (rx_addr_ff == BCAST_ADDR);
  assign addr_me = (rx_addr_ff == MY_ADDR) && !addr_bcast;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ack_ok_ff <= 1'b0;
    end else if (pkt_end) begin
      ack_ok_ff <= sum_ok;
    end
  end

  // ---------------------------------------------------------------
  // inter-byte gap timer
  // ---------------------------------------------------------------

  assign gap_run = (state_ff == ST_RECV) && (rx_field_ff != F_HDR) &&
                   !RX_VALID;

  hphe_timer #(
    .LIMIT(GAP_CYCLES)
  ) u_gap_timer (
    .clk(CLK),
    .rst_n(RST_N),
    .run(gap_run),
    .expired(gap_expired)
  );

  // ---------------------------------------------------------------
  // transaction sequencer
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_RECV: begin
        if (pkt_end && addr_me) begin
          nxt_state = ST_ACK;
        end
      end
      ST_ACK: begin
        if (buf_in_ready) begin
          nxt_state = ack_ok_ff ? ST_EXEC : ST_RECV;
        end
      end
      ST_EXEC: begin
        if (RSP_VALID) begin
          nxt_state = ST_SEND;
        end
      end
      ST_SEND: begin
        if (tx_push && (tx_field_ff == F_SUM)) begin
          nxt_state = ST_REPLY;
        end
      end
      ST_REPLY: begin
        if (reply_fire) begin
          nxt_state = (RX_DATA == NAK_BYTE) ? ST_SEND : ST_RECV;
        end else if (reply_expired || RX_VALID) begin
          nxt_state = ST_RECV;
        end
      end
      default: nxt_state = ST_RECV;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_ff <= ST_RECV;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // an addressed command is released only after the ack byte is queued; a broadcast one right after its checksum byte
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cmd_valid_ff <= 1'b0;
      cmd_bcast_ff <= 1'b0;
    end else begin
      cmd_valid_ff <= (pkt_end && addr_bcast && sum_ok) ||
                      ((state_ff == ST_ACK) && buf_in_ready && ack_ok_ff);
      if (pkt_end) begin
        cmd_bcast_ff <= addr_bcast;
      end
    end
  end

  assign RSP_READY = (state_ff == ST_EXEC);

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rsp_is_data_ff <= 1'b0;
      rsp_status_ff <= CSR_ACCEPTED;
      rsp_len_ff <= RST_BYTE;
    end else if ((state_ff == ST_EXEC) && RSP_VALID) begin
      rsp_is_data_ff <= RSP_IS_DATA;
      rsp_status_ff <= RSP_STATUS;
      rsp_len_ff <= RSP_IS_DATA ? RSP_LEN : 8'h01;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rsp_done_ff <= 1'b0;
    end else begin
      rsp_done_ff <= (state_ff == ST_REPLY) && (nxt_state == ST_RECV);
    end
  end

  assign reply_run = (state_ff == ST_REPLY) && !TX_VALID && !RX_VALID;

  hphe_timer #(
    .LIMIT(REPLY_CYCLES)
  ) u_reply_timer (
    .clk(CLK),
    .rst_n(RST_N),
    .run(reply_run),
    .expired(reply_expired)
  );

  // ---------------------------------------------------------------
  // response framing
  // ---------------------------------------------------------------
  assign enter_send = (nxt_state == ST_SEND) && (state_ff != ST_SEND);
  assign tx_push = (state_ff == ST_SEND) && buf_in_ready;

  always_comb begin
    tx_byte = RST_BYTE;
    nxt_tx_field = F_HDR;
    unique case (tx_field_ff)
      F_HDR: begin
        tx_byte = {MY_ADDR, hdr_cnt(rsp_len_ff)};
        nxt_tx_field = F_CMD;
      end
      F_CMD: begin
        tx_byte = rx_cmd_ff;
        // long responses add a length byte
        nxt_tx_field = next_field(F_CMD, {5'h00, hdr_cnt(rsp_len_ff)}, 8'h00);
      end
      F_LEN: begin
        tx_byte = rsp_len_ff;
        nxt_tx_field = next_field(F_LEN, rsp_len_ff, 8'h00);
      end
      F_DATA: begin
        tx_byte = rsp_is_data_ff ? RSP_RDATA : rsp_status_ff;
        nxt_tx_field = next_field(F_DATA, rsp_len_ff, tx_idx_ff);
      end
      F_SUM: begin
        tx_byte = tx_xor_ff;
        nxt_tx_field = F_HDR;
      end
      default: begin
        tx_byte = RST_BYTE;
        nxt_tx_field = F_HDR;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      tx_field_ff <= F_HDR;
      tx_idx_ff <= RST_BYTE;
      tx_xor_ff <= RST_BYTE;
    end else if (enter_send) begin
      tx_field_ff <= F_HDR;
      tx_idx_ff <= RST_BYTE;
      tx_xor_ff <= RST_BYTE;
    end else if (tx_push) begin
      tx_field_ff <= nxt_tx_field;
      tx_xor_ff <= tx_xor_ff ^ tx_byte;
      if (tx_field_ff == F_DATA) begin
        tx_idx_ff <= tx_idx_ff + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // output buffer
  // ---------------------------------------------------------------
  // the sequencer stalls on a full buffer, so no byte is lost
  assign buf_in_valid = (state_ff == ST_ACK) || (state_ff == ST_SEND);
  assign buf_in_data = (state_ff == ST_ACK) ?
                       (ack_ok_ff ? ACK_BYTE : NAK_BYTE) : tx_byte;

  hphe_fifo2 #(
    .WIDTH(BYTE_W),
    .DEPTH(2)
  ) u_tx_buf (
    .clk(CLK),
    .rst_n(RST_N),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(TX_VALID),
    .out_ready(TX_READY),
    .out_data(TX_DATA)
  );

  assign CMD_VALID = cmd_valid_ff;
  assign CMD_NUM = rx_cmd_ff;
  assign CMD_LEN = rx_len_ff;
  assign CMD_BCAST = cmd_bcast_ff;
  assign CMD_RDATA = cmd_rdata_ff;
  assign RSP_IDX = tx_idx_ff;
  assign RSP_DONE = rsp_done_ff;
endmodule : hphe_engine
`default_nettype wire

// ---- core/hphe_pkg.sv ----
// What this block does
// - check address and checksum of each packet
// - foreign address: stay silent, clear, wait
// - bad checksum for us: send 15h
// - good packet for us: send 06h first
// - data request answered with data packet
// - other commands answered with status byte
// - host 06h after response: go idle
// - host 15h after response: resend, unlimited
// - no host reply counts as 06h
// - header: address bits 7..3, count 2..0
// - count 7 means extra length byte
// - last byte is XOR of all before
// - address 0: execute, never answer
`default_nettype none
package hphe_pkg;

  localparam int unsigned BYTE_W = 8;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned CNT_W = 3;
  localparam int unsigned MAX_DATA = 255;

  // header layout
  localparam int unsigned HDR_ADDR_LSB = 3;
  localparam logic [CNT_W-1:0] LONG_CNT = 3'h7;
  localparam logic [ADDR_W-1:0] BCAST_ADDR = 5'h00;

  localparam logic [BYTE_W-1:0] ACK_BYTE = 8'h06;
  localparam logic [BYTE_W-1:0] NAK_BYTE = 8'h15;
  localparam logic [BYTE_W-1:0] CSR_ACCEPTED = 8'h00;
  localparam logic [BYTE_W-1:0] RST_BYTE = 8'h00;

  // timing
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned GAP_TIME_US = 1000;
  localparam int unsigned GAP_CYCLES = GAP_TIME_US * CLK_MHZ;
  localparam int unsigned REPLY_TIME_MS = 100;
  localparam int unsigned REPLY_CYCLES = REPLY_TIME_MS * 1000 * CLK_MHZ;

  typedef enum logic [4:0] {
    ST_RECV = 5'h01,
    ST_ACK = 5'h02,
    ST_EXEC = 5'h04,
    ST_SEND = 5'h08,
    ST_REPLY = 5'h10
  } hphe_state_t;

  typedef enum logic [4:0] {
    F_HDR = 5'h01,
    F_CMD = 5'h02,
    F_LEN = 5'h04,
    F_DATA = 5'h08,
    F_SUM = 5'h10
  } hphe_field_t;

  // three-bit header count for a data length
  function automatic logic [CNT_W-1:0] hdr_cnt(input logic [7:0] len);
    hdr_cnt = (len >= 8'h07) ? LONG_CNT : len[CNT_W-1:0];
  endfunction : hdr_cnt

  // field sequencing shared by receive and transmit
  function automatic hphe_field_t next_field(input hphe_field_t f,
                                            input logic [7:0] len,
                                            input logic [7:0] idx);
    next_field = F_HDR;
    unique case (f)
      F_HDR: next_field = F_CMD;
      F_CMD: begin
        if (len == {5'h00, LONG_CNT}) begin
          next_field = F_LEN;
        end else begin
          next_field = (len == 8'h00) ? F_SUM : F_DATA;
        end
      end
      F_LEN: next_field = (len == 8'h00) ? F_SUM : F_DATA;
      F_DATA: next_field = (idx == len - 8'h01) ? F_SUM : F_DATA;
      F_SUM: next_field = F_HDR;
      default: next_field = F_HDR;
    endcase
  endfunction : next_field

endpackage : hphe_pkg
`default_nettype wire

// ---- core/hphe_fifo2.sv ----
`timescale 1ns/10ps
`default_nettype none
module hphe_fifo2 #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ff;
  logic [PW-1:0] rd_ff;
  logic [PW:0] cnt_ff;
  logic push;
  logic pop;

  assign in_ready = (cnt_ff != (PW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rd_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
    wrap_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : wrap_inc

  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= wrap_inc(wr_ff);
      end
      if (pop) begin
        rd_ff <= wrap_inc(rd_ff);
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule : hphe_fifo2
`default_nettype wire

// ---- core/hphe_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
// one-cycle expiry pulse after LIMIT cycles of run; dropping run restarts
module hphe_timer #(
  parameter int unsigned LIMIT = 16,
  parameter int unsigned W = $clog2(LIMIT + 1)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  output logic expired
);
  logic [W-1:0] cnt_ff;

  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      cnt_ff <= '0;
    end else if (cnt_ff != W'(LIMIT)) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign expired = run && (cnt_ff == W'(LIMIT - 1));
endmodule : hphe_timer
`default_nettype wire

// ---- dv/hphe_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module hphe_chk #(
  parameter int unsigned GAP_CYCLES = 20,
  parameter int unsigned REPLY_CYCLES = 50,
  parameter int unsigned MAX_DATA = 255
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [hphe_pkg::ADDR_W-1:0] MY_ADDR,
  input wire logic RX_VALID,
  input wire logic [hphe_pkg::BYTE_W-1:0] RX_DATA,
  input wire logic RX_READY,
  input wire logic TX_VALID,
  input wire logic [hphe_pkg::BYTE_W-1:0] TX_DATA,
  input wire logic TX_READY,
  input wire logic CMD_VALID,
  input wire logic CMD_BCAST,
  input wire logic RSP_VALID,
  input wire logic RSP_READY,
  input wire logic RSP_DONE
);
  import hphe_pkg::*;
  logic in_rsp_ff;
  int unsigned quiet_ff;
  // ----
  // span from a taken response to the end of the transaction
  // ----
  always_ff @(posedge CLK) begin
    if (!RST_N || RSP_DONE) in_rsp_ff <= 1'b0;
    else if (RSP_VALID && RSP_READY) in_rsp_ff <= 1'b1;
  end
  // silence only counts once the output buffer has drained
  always_ff @(posedge CLK) begin
    if (!RST_N || !in_rsp_ff || TX_VALID || RX_VALID) quiet_ff <= 0;
    else quiet_ff <= quiet_ff + 1;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  tx_hold_a: assert property (
    TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
    else $error("stalled output byte changed");
  ack_first_a: assert property (
    CMD_VALID && !CMD_BCAST |-> TX_VALID && TX_DATA == ACK_BYTE)
    else $error("command issued without acknowledge at head");
  bcast_quiet_a: assert property (
    CMD_VALID && CMD_BCAST |-> !TX_VALID [*8])
    else $error("broadcast was answered");
  cmd_pulse_a: assert property (
    CMD_VALID |=> !CMD_VALID)
    else $error("command strobe longer than one cycle");
  exec_hold_a: assert property (
    RSP_READY |-> !RX_READY)
    else $error("byte taken while awaiting response");
  ack_idle_a: assert property (
    in_rsp_ff && RX_VALID && RX_READY && RX_DATA == ACK_BYTE
    |-> ##[1:3] RSP_DONE ##[0:1] RX_READY)
    else $error("host acknowledge did not end transaction");
  nak_resend_a: assert property (
    in_rsp_ff && RX_VALID && RX_READY && RX_DATA == NAK_BYTE
    |-> ##[1:6] TX_VALID && TX_DATA[7:3] == MY_ADDR)
    else $error("no resend after host negative reply");
  nak_nodone_a: assert property (
    in_rsp_ff && RX_VALID && RX_READY && RX_DATA == NAK_BYTE
    |=> !RSP_DONE [*4])
    else $error("transaction ended on negative reply");
  reply_limit_a: assert property (
    quiet_ff <= REPLY_CYCLES + 4)
    else $error("reply wait overran its limit");
endmodule : hphe_chk
bind hphe_engine hphe_chk #(
  .GAP_CYCLES(GAP_CYCLES), .REPLY_CYCLES(REPLY_CYCLES), .MAX_DATA(MAX_DATA)
) chk (
  .CLK, .RST_N, .MY_ADDR, .RX_VALID, .RX_DATA, .RX_READY, .TX_VALID,
  .TX_DATA, .TX_READY, .CMD_VALID, .CMD_BCAST, .RSP_VALID, .RSP_READY,
  .RSP_DONE
);
`default_nettype wire

// ---- dv/hphe_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module hphe_host (
  input wire logic clk,
  output var logic rx_valid,
  output var logic [7:0] rx_data,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output var logic tx_ready
);
  logic [7:0] got[$];
  bit slow = 1'b0;
  int stuck = 0;
  logic r;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
  end
  // a slow host stalls at random; a byte is popped at the next edge
  always @(negedge clk) begin
    r = slow ? 1'($urandom_range(1, 0)) : 1'b1;
    if (tx_valid === 1'b1 && r) got.push_back(tx_data);
    tx_ready = r;
  end
  // byte held until ready is seen before a rising edge
  task automatic put(input logic [7:0] b);
    int n;
    @(negedge clk);
    rx_valid = 1'b1;
    rx_data = b;
    #1;
    for (n = 0; n < 300 && rx_ready !== 1'b1; n++) begin
      @(negedge clk);
      #1;
    end
    if (n == 300) stuck++;
    @(posedge clk);
  endtask : put
  // released line shows the inverse of its last byte
  task automatic drop();
    @(negedge clk);
    rx_valid = 1'b0;
    rx_data = ~rx_data;
  endtask : drop
  task automatic send(input logic [7:0] q[$]);
    foreach (q[i]) put(q[i]);
    drop();
  endtask : send
endmodule : hphe_host
`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import hphe_pkg::*;
  typedef logic [7:0] hphe_bq_t[$];
  localparam int GAP = 20;
  localparam int RPL = 50;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] my_addr = 5'h0B;
  logic [7:0] cmd_idx = 8'h00;
  logic rsp_valid = 1'b0;
  logic rsp_is_data = 1'b0;
  logic [7:0] rsp_status = 8'h00;
  logic [7:0] rsp_len = 8'h00;
  logic [7:0] rsp_mem [256];
  logic rx_valid, rx_ready, tx_valid, tx_ready, cmd_valid, cmd_bcast;
  logic rsp_ready, rsp_done;
  logic [7:0] rx_data, tx_data, cmd_num, cmd_len, cmd_rdata, rsp_idx;
  logic [7:0] rsp_rdata;
  int fail_count = 0;
  int check_count = 0;
  int cmd_seen = 0;
  int done_seen = 0;
  bit rsp_go = 1'b0;
  always #5 clk = ~clk;
  assign rsp_rdata = rsp_mem[rsp_idx];
  hphe_engine #(.GAP_CYCLES(GAP), .REPLY_CYCLES(RPL)) uut (
    .CLK(clk), .RST_N(rst_n), .MY_ADDR(my_addr), .RX_VALID(rx_valid),
    .RX_DATA(rx_data), .RX_READY(rx_ready), .TX_VALID(tx_valid),
    .TX_DATA(tx_data), .TX_READY(tx_ready), .CMD_VALID(cmd_valid),
    .CMD_NUM(cmd_num), .CMD_LEN(cmd_len), .CMD_BCAST(cmd_bcast),
    .CMD_IDX(cmd_idx), .CMD_RDATA(cmd_rdata), .RSP_VALID(rsp_valid),
    .RSP_READY(rsp_ready), .RSP_IS_DATA(rsp_is_data),
    .RSP_STATUS(rsp_status), .RSP_LEN(rsp_len), .RSP_IDX(rsp_idx),
    .RSP_RDATA(rsp_rdata), .RSP_DONE(rsp_done)
  );
  hphe_host host (
    .clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready)
  );
  // ----
  // application side: answers every addressed command once
  // ----
  always @(negedge clk) begin
    if (rsp_go) rsp_valid = 1'b0;
    if (cmd_valid === 1'b1) begin
      cmd_seen++;
      if (cmd_bcast !== 1'b1) rsp_valid = 1'b1;
    end
    // ready is settled here, so this is the handshake of the coming edge
    rsp_go = rsp_valid && rsp_ready === 1'b1;
    if (rsp_done === 1'b1) done_seen++;
  end
  task automatic print_verdict();
    $display("checks %0d failures %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic limit(input bit hit);
    if (hit || host.stuck != 0) begin
      fail_count++;
      $display("FAIL %0t wait limit reached", $time);
      print_verdict();
    end
  endtask : limit
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t byte got %h expected %h", $time, got, exp);
    end
  endtask : check8
  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t flag got %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  // reference packet: header, command, optional length, data, xor
  function automatic hphe_bq_t mk(input logic [4:0] a, input logic [7:0] c,
                                  input hphe_bq_t d);
    hphe_bq_t p;
    logic [7:0] s;
    p.push_back({a, (d.size() > 6) ? 3'h7 : 3'(d.size())});
    p.push_back(c);
    if (d.size() > 6) p.push_back(8'(d.size()));
    foreach (d[i]) p.push_back(d[i]);
    s = 8'h00;
    foreach (p[i]) s ^= p[i];
    p.push_back(s);
    return p;
  endfunction : mk
  task automatic expect_tx(input hphe_bq_t e);
    int n;
    for (n = 0; n < 2000 && host.got.size() < e.size(); n++) @(posedge clk);
    limit(n == 2000);
    foreach (e[i]) check8(host.got.pop_front(), e[i]);
  endtask : expect_tx
  // d0 is taken before the host's reply, so an early done is not missed
  task automatic wait_done(input int d0, output int n);
    for (n = 0; n < 500 && done_seen == d0; n++) @(negedge clk);
    limit(n == 500);
  endtask : wait_done
  // one addressed command with its answer, naks resends, optional silence
  task automatic txn(input logic [7:0] c, input int dl, input bit dat,
                     input int rl, input int naks, input bit quiet);
    hphe_bq_t d, r, rp;
    int n;
    int d0;
    for (n = 0; n < dl; n++) d.push_back(8'($urandom));
    for (n = 0; n < rl; n++) begin
      rsp_mem[n] = 8'($urandom);
      r.push_back(rsp_mem[n]);
    end
    rsp_is_data = dat;
    rsp_len = 8'(rl);
    rsp_status = {6'h00, c[1:0]};
    if (!dat) r = '{rsp_status};
    host.send(mk(my_addr, c, d));
    expect_tx('{ACK_BYTE});
    check8(cmd_num, c);
    check8(cmd_len, 8'(dl));
    chk_bit(cmd_bcast, 1'b0);
    for (n = 0; n < dl; n++) begin
      @(negedge clk);
      cmd_idx = 8'(n);
      @(negedge clk);
      check8(cmd_rdata, d[n]);
    end
    rp = mk(my_addr, c, r);
    expect_tx(rp);
    repeat (naks) begin
      host.send('{NAK_BYTE});
      expect_tx(rp);
    end
    d0 = done_seen;
    if (!quiet) host.send('{ACK_BYTE});
    wait_done(d0, n);
    if (quiet) chk_bit(n >= RPL - 4 && n < RPL + 20, 1'b1);
  endtask : txn
  initial begin
    int n;
    int k;
    hphe_bq_t p;
    foreach (rsp_mem[i]) rsp_mem[i] = 8'h00;
    n = $urandom(40924);
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk_bit(rx_ready, 1'b1);
    chk_bit(tx_valid | cmd_valid | rsp_ready | rsp_done, 1'b0);
    txn(8'h40, 2, 1'b0, 0, 0, 1'b0);
    txn(8'h23, 7, 1'b1, 7, 2, 1'b1);
    host.slow = 1'b1;
    txn(8'h81, 6, 1'b1, 3, 1, 1'b0);
    host.slow = 1'b0;
    n = cmd_seen;
    p = mk(my_addr, 8'h12, '{8'h5A});
    p[p.size()-1] ^= 8'h01;
    host.send(p);
    expect_tx('{NAK_BYTE});
    check8(8'(cmd_seen - n), 8'h00);
    txn(8'h12, 1, 1'b0, 0, 0, 1'b0);
    n = cmd_seen;
    host.send(mk(my_addr ^ 5'h01, 8'h12, '{8'h5A}));
    repeat (20) @(negedge clk);
    check8(8'(host.got.size()), 8'h00);
    check8(8'(cmd_seen - n), 8'h00);
    host.send(mk(5'h00, 8'h33, '{}));
    for (k = 0; k < 50 && cmd_seen == n; k++) @(negedge clk);
    limit(k == 50);
    chk_bit(cmd_bcast, 1'b1);
    repeat (20) @(negedge clk);
    check8(8'(host.got.size()), 8'h00);
    host.put({my_addr, 3'h2});
    host.put(8'h44);
    host.drop();
    repeat (GAP + 5) @(negedge clk);
    txn(8'h50, 0, 1'b0, 0, 0, 1'b0);
    for (k = 0; k < 4; k++) begin
      txn(8'($urandom), $urandom_range(12, 0), 1'($urandom),
          $urandom_range(9, 0), $urandom_range(1, 0), 1'b0);
    end
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
